// ==== design/tmr_pkg.sv ====
// Constants, register map and carrier types for the eight-bit timer
package tmr_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_COUNT = 8'h01;
   localparam logic [7:0] ADDR_INTCTL = 8'h0b;
   localparam logic [7:0] ADDR_OPTION = 8'h81;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h21;

   // ==========================================================
   // Values after reset
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_INTCTL = 8'h00;
   localparam logic [7:0] RST_OPTION = 8'hff;
   localparam logic [7:0] RST_PRESC = 8'h00;

   // ==========================================================
   // Field positions
   localparam int OPT_SRC_BIT = 5;
   localparam int OPT_EDGE_BIT = 4;
   localparam int OPT_OWNER_BIT = 3;
   localparam int OPT_RATIO_MSB = 2;
   localparam int INT_IE_BIT = 5;
   localparam int INT_IF_BIT = 2;

   // ==========================================================
   // Counts of cycles
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      PH_Q1 = 4'b0001,
      PH_Q2 = 4'b0010,
      PH_Q3 = 4'b0100,
      PH_Q4 = 4'b1000
   } phase_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// ==== design/ratio_prescaler.sv ====
// Shared eight-bit prescaler count, cleared or stepped by its owner
`timescale 1ns/1ns
`default_nettype none
module ratio_prescaler
   import tmr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic clear_in,
   input wire logic step_in,
   output logic [7:0] count_out
);

   logic [7:0] count_ff;
   logic [7:0] nxt_count;

   // ==========================================================
   // Clear beats a step arriving in the same cycle
   assign nxt_count = clear_in ? RST_PRESC : (step_in ? count_ff + 8'h01 : count_ff);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         count_ff <= RST_PRESC;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign count_out = count_ff;

endmodule
`default_nettype wire

// ==== design/tmr_top.sv ====
// Eight-bit timer/counter with prescaler shared with the watchdog unit
// Function
// - Source bit clear counts instruction cycles; set counts ext_count_pin edges.
// - Edge select clear counts rising pin edges, set counts falling edges.
// - Wrap from FFh to 00h sets overflow flag; interrupt only when enabled.
// - A count register write blocks increments for the next two instruction cycles.
// - Without prescaler the pin itself is the prescaler output being synchronized.
// - Prescaler output is sampled in the second and fourth phase of each cycle.
// - One prescaler, owned by timer or watchdog; the other runs unprescaled.
// - Software has no read or write path to the prescaler count.
// - Low four option bits pick owner and ratio: timer 1:2..1:256, watchdog 1:1..1:128.
// - Owner bit clear gives prescaler to timer, set gives it to the watchdog.
// - With timer owning it, a count register write clears the prescaler.
// - A count register write never changes the prescaler owner.
// - With watchdog owning it, watchdog clear clears prescaler and watchdog count.
`timescale 1ns/1ns
`default_nettype none
module tmr_top
   import tmr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire tmr_pkg::reg_req_s bus_req_in,
   output logic [7:0] bus_rdata_out,
   input wire logic ext_count_pin_in,
   input wire logic watchdog_clear_instruction_in,
   input wire logic watchdog_unit_tick_in,
   output logic watchdog_unit_tick_out,
   output logic watchdog_unit_clear_out,
   output logic irq_out
);
   import tmr_pkg::*;

   // ==========================================================
   // State
   phase_e phase_ff;
   phase_e nxt_phase;
   logic [7:0] count_ff;
   logic [7:0] intctl_ff;
   logic [7:0] option_ff;
   logic [1:0] inhibit_ff;
   logic flag_ff;
   logic edge_prev_ff;
   logic samp_ff;
   logic [7:0] rdata_ff;
   logic dog_tick_ff;
   logic dog_clear_ff;

   // ==========================================================
   // Instruction phases, four clocks per instruction cycle
   always_comb begin
      case (phase_ff)
         PH_Q1: nxt_phase = PH_Q2;
         PH_Q2: nxt_phase = PH_Q3;
         PH_Q3: nxt_phase = PH_Q4;
         PH_Q4: nxt_phase = PH_Q1;
         default: nxt_phase = PH_Q1;
      endcase
   end

   wire q2 = (phase_ff == PH_Q2);
   wire q4 = (phase_ff == PH_Q4);
   wire sample_en = q2 | q4;

   // ==========================================================
   // Write decode
   wire wr_count = bus_req_in.wr && (bus_req_in.addr == ADDR_COUNT);
   wire wr_intctl = bus_req_in.wr && (bus_req_in.addr == ADDR_INTCTL);
   wire wr_option = bus_req_in.wr && (bus_req_in.addr == ADDR_OPTION);
   wire wr_irq_clear = bus_req_in.wr && (bus_req_in.addr == ADDR_IRQ_CLEAR);
   wire irq_clr = wr_irq_clear && bus_req_in.wdata[INT_IF_BIT];

   // ==========================================================
   // Option fields
   wire ext_mode = option_ff[OPT_SRC_BIT];
   wire owner_dog = option_ff[OPT_OWNER_BIT];
   wire [2:0] ratio = option_ff[OPT_RATIO_MSB:0];

   // Low ratio+1 bits for timer (1:2..1:256), low ratio bits for watchdog (1:1..1:128)
   wire [8:0] tmr_span = 9'h001 << ({1'b0, ratio} + 4'h1);
   wire [8:0] dog_span = 9'h001 << ratio;
   wire [7:0] tmr_mask = tmr_span[7:0] - 8'h01;
   wire [7:0] dog_mask = dog_span[7:0] - 8'h01;

   // ==========================================================
   // Pin edge: falling edge selection inverts the pin first
   wire edge_lvl = ext_count_pin_in ^ option_ff[OPT_EDGE_BIT];
   wire edge_rise = edge_lvl & ~edge_prev_ff;
   wire timer_step = ext_mode ? edge_rise : q4;

   // ==========================================================
   // Shared prescaler
   logic [7:0] presc_cnt;
   wire presc_step = owner_dog ? watchdog_unit_tick_in : timer_step;
   wire clr_by_timer = wr_count & ~owner_dog;
   wire clr_by_dog = watchdog_clear_instruction_in & owner_dog;
   wire presc_clear = clr_by_timer | clr_by_dog;

   // Count is internal only; no register decode reaches it
   ratio_prescaler u_presc (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .clear_in(presc_clear),
      .step_in(presc_step),
      .count_out(presc_cnt)
   );

   wire presc_full_t = ((presc_cnt & tmr_mask) == tmr_mask);
   wire presc_full_d = ((presc_cnt & dog_mask) == dog_mask);

   // Watchdog runs unprescaled whenever the timer owns the prescaler
   wire dog_tick = owner_dog ? (presc_step & presc_full_d) : watchdog_unit_tick_in;

   // ==========================================================
   // Increment request
   // Pin path: prescaler bit at the ratio rises once per N edges, or raw pin when bypassed
   wire presc_out = owner_dog ? edge_lvl : presc_cnt[ratio];
   wire ext_inc = sample_en & presc_out & ~samp_ff;
   wire int_inc = owner_dog ? q4 : (q4 & presc_full_t);
   wire inc_req = ext_mode ? ext_inc : int_inc;
   wire inc_ok = inc_req && (inhibit_ff == 2'h0) && !wr_count;
   wire overflow = inc_ok && (count_ff == COUNT_MAX);

   // ==========================================================
   // Read decode
   logic [7:0] rmux;
   always_comb begin
      if (bus_req_in.addr == ADDR_COUNT) begin
         rmux = count_ff;
      end else if (bus_req_in.addr == ADDR_INTCTL) begin
         rmux = {intctl_ff[7:3], flag_ff, intctl_ff[1:0]};
      end else if (bus_req_in.addr == ADDR_OPTION) begin
         rmux = option_ff;
      end else if (bus_req_in.addr == ADDR_IRQ_STATUS) begin
         rmux = {5'h00, flag_ff, 2'h0};
      end else begin
         rmux = 8'h00;
      end
   end

   // ==========================================================
   // Phase and bus
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         phase_ff <= PH_Q1;
         rdata_ff <= 8'h00;
      end else begin
         phase_ff <= nxt_phase;
         rdata_ff <= bus_req_in.rd ? rmux : 8'h00;
      end
   end

   // ==========================================================
   // Configuration registers; flag bit of control is not stored here
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         intctl_ff <= RST_INTCTL;
         option_ff <= RST_OPTION;
      end else begin
         if (wr_intctl) begin
            intctl_ff <= bus_req_in.wdata & 8'hfb;
         end
         if (wr_option) begin
            option_ff <= bus_req_in.wdata;
         end
      end
   end

   // ==========================================================
   // Counter and write inhibit
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         count_ff <= RST_COUNT;
         inhibit_ff <= 2'h0;
      end else if (wr_count) begin
         count_ff <= bus_req_in.wdata;
         inhibit_ff <= INHIBIT_CYCLES;
      end else begin
         if (inc_ok) begin
            count_ff <= count_ff + 8'h01;
         end
         if (q4 && (inhibit_ff != 2'h0)) begin
            inhibit_ff <= inhibit_ff - 2'h1;
         end
      end
   end

   // ==========================================================
   // Sampling and edge history
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         // Reset options pick falling edges, so an idle low pin reads 1; no false count
         edge_prev_ff <= 1'b1;
         samp_ff <= 1'b1;
      end else begin
         edge_prev_ff <= edge_lvl;
         if (sample_en) begin
            samp_ff <= presc_out;
         end
      end
   end

   // ==========================================================
   // Sticky overflow flag; a new overflow wins over a clear
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         flag_ff <= 1'b0;
      end else if (overflow) begin
         flag_ff <= 1'b1;
      end else if (irq_clr) begin
         flag_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Watchdog side pulses
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         dog_tick_ff <= 1'b0;
         dog_clear_ff <= 1'b0;
      end else begin
         dog_tick_ff <= dog_tick;
         dog_clear_ff <= watchdog_clear_instruction_in;
      end
   end

   assign bus_rdata_out = rdata_ff;
   assign watchdog_unit_tick_out = dog_tick_ff;
   assign watchdog_unit_clear_out = dog_clear_ff;
   assign irq_out = flag_ff & intctl_ff[INT_IE_BIT];

   // ==========================================================
   // Assertions
   timer_tick_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (q4 && !ext_mode && owner_dog && inhibit_ff == 2'h0 && !wr_count)
      |=> count_ff == $past(count_ff) + 8'h01)
      else $error("timer did not advance on instruction cycle");

   edge_count_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ext_mode && owner_dog && sample_en && edge_lvl && !samp_ff
       && inhibit_ff == 2'h0 && !wr_count)
      |=> count_ff == $past(count_ff) + 8'h01)
      else $error("selected pin edge not counted");

   sample_phase_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ext_mode && !sample_en && !wr_count) |=> count_ff == $past(count_ff))
      else $error("pin count changed outside sampling phases");

   overflow_set_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (inc_ok && count_ff == COUNT_MAX) |=> (flag_ff && count_ff == 8'h00))
      else $error("wrap did not set overflow flag");

   irq_gate_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !intctl_ff[INT_IE_BIT] |-> !irq_out)
      else $error("interrupt raised while disabled");

   write_inhibit_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_count ##1 (!wr_count)[*8] |=> count_ff == $past(count_ff, 8))
      else $error("count advanced within two cycles after write");

   presc_clear_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (wr_count && !owner_dog && !wr_option)
      |=> (presc_cnt == 8'h00 && option_ff == $past(option_ff)))
      else $error("count write mishandled prescaler");

   dog_clear_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (watchdog_clear_instruction_in && owner_dog)
      |=> (presc_cnt == 8'h00 && watchdog_unit_clear_out))
      else $error("watchdog clear missed prescaler");

   dog_bypass_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !owner_dog |=> watchdog_unit_tick_out == $past(watchdog_unit_tick_in))
      else $error("watchdog prescaled while timer owns prescaler");

   timer_ratio_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (q4 && !ext_mode && !owner_dog && inhibit_ff == 2'h0 && !wr_count)
      |=> (count_ff != $past(count_ff)) == $past(presc_full_t))
      else $error("timer ignored prescaler ratio");

   owner_hold_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (!owner_dog && !presc_clear && !timer_step && !wr_option)
      |=> presc_cnt == $past(presc_cnt))
      else $error("prescaler moved without its owner stepping");

   flag_sticky_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (flag_ff && !irq_clr) |=> flag_ff)
      else $error("overflow flag dropped without clear");

   unmapped_read_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (bus_req_in.rd && bus_req_in.addr != ADDR_COUNT && bus_req_in.addr != ADDR_INTCTL
       && bus_req_in.addr != ADDR_OPTION && bus_req_in.addr != ADDR_IRQ_STATUS)
      |=> bus_rdata_out == 8'h00)
      else $error("unmapped read returned data");

   presc_bypass_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ext_mode && owner_dog && sample_en)
      |=> samp_ff == $past(edge_lvl))
      else $error("pin level not used as prescaler output");

   phase_step_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      q2 |-> ##2 q4)
      else $error("sampling phases not two clocks apart");

   dog_pass_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (owner_dog && ratio == 3'h0 && watchdog_unit_tick_in)
      |=> watchdog_unit_tick_out)
      else $error("watchdog lowest ratio not one to one");

   dog_quiet_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (owner_dog && !watchdog_unit_tick_in) |=> !watchdog_unit_tick_out)
      else $error("watchdog tick without base tick");

   option_hold_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_count |=> option_ff == $past(option_ff))
      else $error("count write changed prescaler owner");

   dog_hold_a: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (owner_dog && !presc_clear && !watchdog_unit_tick_in)
      |=> presc_cnt == $past(presc_cnt))
      else $error("prescaler moved without watchdog tick");

endmodule
`default_nettype wire

// ==== test/pin_source.sv ====
// External clock source model that toggles the count pin on request
`timescale 1ns/1ns
`default_nettype none
module pin_source (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic start_in,
   input wire logic [3:0] toggles_in,
   output logic pin_out,
   output logic busy_out
);
   // ==========================================================
   // Toggle engine
   logic [3:0] left_ff;
   logic [2:0] hold_ff;

   assign busy_out = (left_ff != 4'h0);

   // Level held 8 clocks, four times the two-clock sampling interval
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         pin_out <= 1'b0;
         left_ff <= 4'h0;
         hold_ff <= 3'h0;
      end else if (start_in && !busy_out) begin
         left_ff <= toggles_in;
         hold_ff <= 3'h0;
      end else if (busy_out) begin
         hold_ff <= hold_ff + 3'h1;
         if (hold_ff == 3'h7) begin
            pin_out <= ~pin_out;
            left_ff <= left_ff - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/tmr_top_bench.sv ====
// Self-checking bench for the eight-bit timer with shared prescaler
`timescale 1ns/1ns
`default_nettype none
module tmr_top_bench;
   import tmr_pkg::*;
   // ==========================================================
   // Signals
   logic clk_sys_in;
   logic rst_b_in;
   reg_req_s req;
   logic [7:0] rdata;
   logic pin;
   logic wd_clr;
   logic wd_tick;
   logic wd_tick_out;
   logic wd_clr_out;
   logic irq;
   logic go;
   logic busy;
   logic [3:0] n_tog;
   int n_errors = 0;
   int check_count = 0;
   int n_tick = 0;

   tmr_top uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus_req_in(req),
      .bus_rdata_out(rdata), .ext_count_pin_in(pin), .watchdog_clear_instruction_in(wd_clr),
      .watchdog_unit_tick_in(wd_tick), .watchdog_unit_tick_out(wd_tick_out),
      .watchdog_unit_clear_out(wd_clr_out), .irq_out(irq));
   pin_source src (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .start_in(go),
      .toggles_in(n_tog), .pin_out(pin), .busy_out(busy));

   // ==========================================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_in);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_in);
      req <= '0;
      #1;
      d = rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   // Gap counts clocks between the two sampling edges
   task automatic rate(input int gap, input logic [7:0] exp);
      logic [7:0] d0;
      logic [7:0] d1;
      rd(ADDR_COUNT, d0);
      repeat (gap - 2) @(posedge clk_sys_in);
      rd(ADDR_COUNT, d1);
      chk(d1 - d0, exp);
   endtask
   task automatic irq_is(input logic e);
      #1;
      chk({7'h00, irq}, {7'h00, e});
   endtask
   task automatic wdc();
      @(posedge clk_sys_in);
      wd_clr <= 1'b1;
      @(posedge clk_sys_in);
      wd_clr <= 1'b0;
      #1;
      chk({7'h00, wd_clr_out}, 8'h01);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_sys_in);
         wd_tick <= 1'b1;
         @(posedge clk_sys_in);
         wd_tick <= 1'b0;
      end
      repeat (3) @(posedge clk_sys_in);
   endtask
   // Seven toggles: four edges of the start level's opposite kind, three of the other
   task automatic ext_run(input logic [7:0] opt);
      logic [7:0] b0;
      int k;
      wr(ADDR_OPTION, opt);
      repeat (16) @(posedge clk_sys_in);
      rd(ADDR_COUNT, b0);
      @(posedge clk_sys_in);
      go <= 1'b1;
      @(posedge clk_sys_in);
      go <= 1'b0;
      #1;
      k = 0;
      while (busy !== 1'b0 && k < 200) begin
         @(posedge clk_sys_in);
         k++;
      end
      repeat (16) @(posedge clk_sys_in);
      rdc(ADDR_COUNT, b0 + 8'h04);
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Clock, tick counter, watchdog
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      if (wd_tick_out === 1'b1) begin
         n_tick++;
      end
   end
   initial begin
      repeat (40000) @(posedge clk_sys_in);
      n_errors++;
      test_done();
   end

   // ==========================================================
   // Tests
   initial begin
      rst_b_in = 1'b0;
      req = '0;
      wd_clr = 1'b0;
      wd_tick = 1'b0;
      go = 1'b0;
      n_tog = 4'h7;
      repeat (3) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      rdc(ADDR_OPTION, RST_OPTION);
      rdc(ADDR_COUNT, RST_COUNT);
      rdc(ADDR_INTCTL, RST_INTCTL);
      rdc(8'h55, 8'h00);
      rdc(ADDR_IRQ_CLEAR, 8'h00);
      wr(ADDR_OPTION, 8'h08);
      wr(ADDR_COUNT, 8'hfd);
      repeat (4) @(posedge clk_sys_in);
      rdc(ADDR_COUNT, 8'hfd);
      rate(16, 8'h04);
      repeat (40) @(posedge clk_sys_in);
      wr(ADDR_INTCTL, 8'h20);
      irq_is(1'b1);
      rdc(ADDR_IRQ_STATUS, 8'h04);
      rdc(ADDR_INTCTL, 8'h24);
      wr(ADDR_INTCTL, 8'h00);
      irq_is(1'b0);
      wr(ADDR_INTCTL, 8'h20);
      irq_is(1'b1);
      wr(ADDR_IRQ_CLEAR, 8'h04);
      irq_is(1'b0);
      rdc(ADDR_IRQ_STATUS, 8'h00);
      for (int r = 0; r < 8; r++) begin
         wr(ADDR_OPTION, 8'(r));
         wr(ADDR_COUNT, 8'h00);
         rdc(ADDR_OPTION, 8'(r));
         repeat (12) @(posedge clk_sys_in);
         rate(64 << r, 8'h08);
      end
      n_tick = 0;
      tick(5);
      chk(8'(n_tick), 8'h05);
      // Clear, then hand over, then clear the watchdog
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_OPTION, 8'h0f);
      wdc();
      // Descending so the 1:1 case follows a different ratio
      for (int r = 7; r >= 0; r--) begin
         wr(ADDR_OPTION, 8'h08 | 8'(r));
         wdc();
         n_tick = 0;
         tick(4 << r);
         chk(8'(n_tick), 8'h04);
      end
      ext_run(8'h28);
      ext_run(8'h38);
      test_done();
   end
endmodule
`default_nettype wire
